/* logic/bft_pkg.sv */
package bft_pkg;
  localparam int          BFT_NUM_INST      = 4;
  localparam int          BFT_CNT_W         = 16;
  localparam int          BFT_PRE_W         = 16;
  localparam logic [11:0] BFT_BASE_ADDR     = 12'hC00;
  localparam logic [11:0] BFT_INST_STRIDE   = 12'h020;
  localparam logic [4:0]  BFT_OFF_COUNT     = 5'h00;
  localparam logic [4:0]  BFT_OFF_RELOAD    = 5'h04;
  localparam logic [4:0]  BFT_OFF_STATUS    = 5'h08;
  localparam logic [4:0]  BFT_OFF_IRQ_EN    = 5'h0C;
  localparam logic [4:0]  BFT_OFF_CTRL      = 5'h10;
  localparam int          BFT_STATUS_BIT    = 0;
  localparam int          BFT_IRQ_EN_BIT    = 0;
  localparam int          BFT_CTRL_ENABLE   = 0;
  localparam int          BFT_CTRL_COUNT_UP = 2;
  localparam int          BFT_CTRL_AUTO_RST = 3;
  localparam int          BFT_CTRL_SOFT_RST = 4;
  localparam int          BFT_CTRL_START    = 5;
  localparam int          BFT_CTRL_RELOAD   = 6;
  localparam int          BFT_CTRL_HALT     = 7;
  localparam int          BFT_CTRL_PRE_LSB  = 16;
  localparam logic [15:0] BFT_CNT_RESET     = 16'h0000;
  localparam logic [15:0] BFT_PRE_RESET     = 16'h0000;
  localparam logic [31:0] BFT_ZERO_WORD     = 32'h0000_0000;
  localparam logic [15:0] BFT_CNT_ONE       = 16'h0001;
  localparam logic [15:0] BFT_CNT_ALL_ONES  = 16'hFFFF;
endpackage

/* logic/bft_prescaler.sv */
`timescale 1ns/1ps
module bft_prescaler
  import bft_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  input  wire logic                 restart_i,
  input  wire logic                 run_i,
  input  wire logic [BFT_PRE_W-1:0] divide_i,
  output logic                      tick_o
);
  logic [BFT_PRE_W-1:0] div_cnt_q;
  logic [BFT_PRE_W-1:0] div_cnt_d;
  wire                  at_end = (div_cnt_q >= divide_i);

  // a tick every divide_i + 1 clocks
  assign tick_o = run_i && !restart_i && at_end;

  always_comb
  begin
    div_cnt_d = div_cnt_q;
    if (restart_i || !run_i || at_end)
    begin
      div_cnt_d = '0;
    end
    else
    begin
      div_cnt_d = div_cnt_q + BFT_CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      div_cnt_q <= '0;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
    end
  end
endmodule

/* logic/bft_timer_bank.sv */
`timescale 1ns/1ps
module bft_timer_bank
  import bft_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    reset_i,
  input  wire logic [11:0]             addr_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  input  wire logic [3:0]              be_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic [BFT_NUM_INST-1:0] lp_req_i,
  output logic      [31:0]             rdata_o,
  output logic      [BFT_NUM_INST-1:0] irq_o,
  output logic      [BFT_NUM_INST-1:0] sleep_o,
  output logic      [BFT_NUM_INST-1:0] lp_grant_o
);
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  lanes);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (lanes[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] widen(input logic [BFT_CNT_W-1:0] v);
    return {{(32-BFT_CNT_W){1'b0}}, v};
  endfunction

  // decode of the four windows
  wire [11:0] rel_addr   = addr_i - BFT_BASE_ADDR;
  wire        in_bank    = (addr_i >= BFT_BASE_ADDR) &&
                           (rel_addr < 12'(BFT_NUM_INST * BFT_INST_STRIDE));
  wire [1:0]  inst_sel   = rel_addr[6:5];
  wire [4:0]  reg_off    = rel_addr[4:0];

  logic [BFT_CNT_W-1:0] count_q   [BFT_NUM_INST];
  logic [BFT_CNT_W-1:0] snap_q    [BFT_NUM_INST];
  logic [BFT_CNT_W-1:0] preload_q [BFT_NUM_INST];
  logic [BFT_PRE_W-1:0] prescale_q[BFT_NUM_INST];
  logic [BFT_NUM_INST-1:0] status_q;
  logic [BFT_NUM_INST-1:0] irq_en_q;
  logic [BFT_NUM_INST-1:0] enable_q;
  logic [BFT_NUM_INST-1:0] up_q;
  logic [BFT_NUM_INST-1:0] auto_q;
  logic [BFT_NUM_INST-1:0] soft_q;
  logic [BFT_NUM_INST-1:0] start_q;
  logic [BFT_NUM_INST-1:0] halt_q;
  logic [31:0]             word_rd [BFT_NUM_INST];

  genvar gi;
  generate
    for (gi = 0; gi < BFT_NUM_INST; gi++)
    begin : g_inst
      wire        hit       = in_bank && (inst_sel == 2'(gi));
      wire        wr_count  = hit && wr_i && (reg_off == BFT_OFF_COUNT);
      wire        wr_reload = hit && wr_i && (reg_off == BFT_OFF_RELOAD);
      wire        wr_status = hit && wr_i && (reg_off == BFT_OFF_STATUS);
      wire        wr_irq_en = hit && wr_i && (reg_off == BFT_OFF_IRQ_EN);
      wire        wr_ctrl   = hit && wr_i && (reg_off == BFT_OFF_CTRL);
      wire        rd_count  = hit && rd_i && (reg_off == BFT_OFF_COUNT);
      wire [31:0] ctrl_word = {prescale_q[gi], 8'h00, halt_q[gi], 1'b0, start_q[gi],
                               soft_q[gi], auto_q[gi], up_q[gi], 1'b0, enable_q[gi]};
      wire [31:0] ctrl_new  = merge_bytes(ctrl_word, wdata_i, be_i);
      wire        inst_rst  = reset_i || soft_q[gi];
      // start rising by write resets the divider and clears flags
      wire        start_set = wr_ctrl && ctrl_new[BFT_CTRL_START] && !start_q[gi];
      wire        run       = enable_q[gi] && start_q[gi] && !halt_q[gi];
      wire        tick;
      wire [BFT_CNT_W-1:0] limit = up_q[gi] ? BFT_CNT_ALL_ONES : BFT_CNT_RESET;
      wire        at_limit  = (count_q[gi] == limit);
      wire        hit_limit = tick && at_limit;
      wire        reload_rq = wr_ctrl && ctrl_new[BFT_CTRL_RELOAD] && start_q[gi];
      wire [31:0] cnt_new   = merge_bytes(widen(count_q[gi]), wdata_i, be_i);
      wire [31:0] pre_new   = merge_bytes(widen(preload_q[gi]), wdata_i, be_i);
      logic [BFT_CNT_W-1:0] count_d;
      logic                 status_d;
      logic                 start_d;

      bft_prescaler u_div (
        .clk_sys_i (clk_sys_i),
        .reset_i   (inst_rst),
        .restart_i (start_set || halt_q[gi]),
        .run_i     (run),
        .divide_i  (prescale_q[gi]),
        .tick_o    (tick)
      );

      always_comb
      begin
        count_d = count_q[gi];
        start_d = start_q[gi];
        if (wr_ctrl)
        begin
          start_d = ctrl_new[BFT_CTRL_START];
        end
        if (wr_count)
        begin
          count_d = cnt_new[BFT_CNT_W-1:0];
        end
        else if (reload_rq)
        begin
          count_d = preload_q[gi];
        end
        else if (hit_limit)
        begin
          if (auto_q[gi])
          begin
            count_d = preload_q[gi];
          end
          else
          begin
            start_d = 1'b0;
          end
        end
        else if (tick)
        begin
          count_d = up_q[gi] ? count_q[gi] + BFT_CNT_ONE
                             : count_q[gi] - BFT_CNT_ONE;
        end
      end

      // set wins over the firmware clear and over the start clear
      always_comb
      begin
        status_d = status_q[gi];
        if (auto_q[gi])
        begin
          status_d = 1'b0;
        end
        else if ((wr_status && be_i[0] && wdata_i[BFT_STATUS_BIT]) || start_set)
        begin
          status_d = 1'b0;
        end
        if (hit_limit)
        begin
          status_d = 1'b1;
        end
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (inst_rst)
        begin
          count_q[gi]    <= BFT_CNT_RESET;
          snap_q[gi]     <= BFT_CNT_RESET;
          preload_q[gi]  <= BFT_PRE_RESET;
          prescale_q[gi] <= '0;
          status_q[gi]   <= 1'b0;
          irq_en_q[gi]   <= 1'b0;
          enable_q[gi]   <= 1'b0;
          up_q[gi]       <= 1'b0;
          auto_q[gi]     <= 1'b0;
          soft_q[gi]     <= 1'b0;
          start_q[gi]    <= 1'b0;
          halt_q[gi]     <= 1'b0;
        end
        else
        begin
          count_q[gi]  <= count_d;
          status_q[gi] <= status_d;
          start_q[gi]  <= start_d;
          // lane 0 read refreshes the snapshot; upper lanes reuse it
          if (rd_count && be_i[0])
          begin
            snap_q[gi] <= count_q[gi];
          end
          if (wr_reload)
          begin
            preload_q[gi] <= pre_new[BFT_CNT_W-1:0];
          end
          if (wr_irq_en && be_i[0])
          begin
            irq_en_q[gi] <= wdata_i[BFT_IRQ_EN_BIT];
          end
          if (wr_ctrl)
          begin
            prescale_q[gi] <= ctrl_new[31:BFT_CTRL_PRE_LSB];
            halt_q[gi]     <= ctrl_new[BFT_CTRL_HALT];
            enable_q[gi]   <= ctrl_new[BFT_CTRL_ENABLE];
            up_q[gi]       <= ctrl_new[BFT_CTRL_COUNT_UP];
            auto_q[gi]     <= ctrl_new[BFT_CTRL_AUTO_RST];
            soft_q[gi]     <= ctrl_new[BFT_CTRL_SOFT_RST];
          end
        end
      end

      always_comb
      begin
        word_rd[gi] = BFT_ZERO_WORD;
        case (reg_off)
          BFT_OFF_COUNT:
          begin
            word_rd[gi] = be_i[0] ? widen(count_q[gi]) : widen(snap_q[gi]);
          end
          BFT_OFF_RELOAD:
          begin
            word_rd[gi] = widen(preload_q[gi]);
          end
          BFT_OFF_STATUS:
          begin
            word_rd[gi][BFT_STATUS_BIT] = status_q[gi];
          end
          BFT_OFF_IRQ_EN:
          begin
            word_rd[gi][BFT_IRQ_EN_BIT] = irq_en_q[gi];
          end
          BFT_OFF_CTRL:
          begin
            word_rd[gi] = ctrl_word;
          end
          default:
          begin
            word_rd[gi] = BFT_ZERO_WORD;
          end
        endcase
      end

      // outputs registered; irq lags the flag by one clock
      always_ff @(posedge clk_sys_i)
      begin
        if (reset_i)
        begin
          irq_o[gi]      <= 1'b0;
          sleep_o[gi]    <= 1'b1;
          lp_grant_o[gi] <= 1'b0;
        end
        else
        begin
          irq_o[gi]      <= status_q[gi] && irq_en_q[gi];
          sleep_o[gi]    <= !enable_q[gi] || !start_q[gi] || halt_q[gi];
          lp_grant_o[gi] <= lp_req_i[gi] && !start_q[gi];
        end
      end
    end
  endgenerate

  wire [31:0] rd_word = in_bank ? word_rd[inst_sel] : BFT_ZERO_WORD;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rdata_o <= BFT_ZERO_WORD;
    end
    else if (rd_i)
    begin
      rdata_o <= rd_word;
    end
  end
endmodule

/* sim/bft_timer_bank_sva.sv */
`timescale 1ns/1ps
module bft_timer_bank_sva
  import bft_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [11:0] addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [3:0]  be_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0]  lp_req_i,
  input wire logic [31:0] rdata_o,
  input wire logic [3:0]  irq_o,
  input wire logic [3:0]  sleep_o,
  input wire logic [3:0]  lp_grant_o
);
  wire in_bank = addr_i[11:7] == 5'h18;
  wire ctl_w0  = wr_i && be_i[0] && addr_i == BFT_BASE_ADDR + 12'(BFT_OFF_CTRL);
  wire ien_w0  = wr_i && be_i[0] && addr_i == BFT_BASE_ADDR + 12'(BFT_OFF_IRQ_EN);
  wire wide_rd = rd_i && in_bank && (addr_i[4:0] == BFT_OFF_COUNT || addr_i[4:0] == BFT_OFF_RELOAD);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  rst_outputs_a: assert property ($fell(reset_i) |-> sleep_o == 4'hF && irq_o == 4'h0
    && lp_grant_o == 4'h0 && rdata_o == 32'h0000_0000) else $error("outputs not at reset value");
  grant_req_a: assert property ((lp_grant_o & ~$past(lp_req_i)) == 4'h0)
    else $error("grant without request");
  grant_sleep_a: assert property ((lp_grant_o & ~sleep_o) == 4'h0)
    else $error("grant while active");
  unmapped_zero_a: assert property (rd_i && !in_bank |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (wide_rd |=> rdata_o[31:16] == 16'h0000)
    else $error("upper count bits not zero");
  status_bits_a: assert property (rd_i && in_bank && addr_i[4:0] == BFT_OFF_STATUS
    |=> rdata_o[31:1] == 31'h0) else $error("reserved status bits set");
  ctrl_sleep_a: assert property (ctl_w0 && (wdata_i[7] || !wdata_i[0] || !wdata_i[5])
    |-> ##2 sleep_o[0]) else $error("not asleep when idle");
  irq_gate_a: assert property (ien_w0 && !wdata_i[0] |-> ##2 !irq_o[0])
    else $error("event passes disabled gate");
  soft_rst_a: assert property (ctl_w0 && wdata_i[4] |-> ##3 sleep_o[0] && !irq_o[0])
    else $error("soft reset left instance active");
endmodule
bind bft_timer_bank bft_timer_bank_sva u_sva (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .be_i(be_i), .wdata_i(wdata_i),
  .lp_req_i(lp_req_i), .rdata_o(rdata_o), .irq_o(irq_o), .sleep_o(sleep_o),
  .lp_grant_o(lp_grant_o));

/* sim/bft_timer_bank_tb.sv */
`timescale 1ns/1ps
module bft_timer_bank_tb
  import bft_pkg::*;
  ;
  localparam logic [4:0] OC = BFT_OFF_COUNT;
  localparam logic [4:0] OR = BFT_OFF_RELOAD;
  localparam logic [4:0] OS = BFT_OFF_STATUS;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic [11:0] addr_i    = 12'h000;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [3:0]  be_i      = 4'h0;
  logic [31:0] wdata_i   = 32'h0000_0000;
  logic [3:0]  lp_req_i  = 4'h0;
  logic [31:0] rdata_o;
  logic [3:0]  irq_o;
  logic [3:0]  sleep_o;
  logic [3:0]  lp_grant_o;
  logic [31:0] v1;
  logic [31:0] v2;
  int          err_total   = 0;
  int          comparisons = 0;
  int          c;
  bft_timer_bank u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .be_i(be_i), .wdata_i(wdata_i), .lp_req_i(lp_req_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .sleep_o(sleep_o), .lp_grant_o(lp_grant_o));
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic tk(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // strobes last one cycle; rdata_o settles on the edge that ends the task
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] v);
    tk(1);
    wr_i = w;
    rd_i = !w;
    addr_i = a;
    wdata_i = d;
    be_i = b;
    tk(1);
    wr_i = 1'b0;
    rd_i = 1'b0;
    v = rdata_o;
  endtask
  task automatic w0(input logic [4:0] o, input logic [31:0] d);
    acc(1'b1, BFT_BASE_ADDR + 12'(o), d, 4'hF, v2);
  endtask
  task automatic r0(input logic [4:0] o, input logic [3:0] b, output logic [31:0] v);
    acc(1'b0, BFT_BASE_ADDR + 12'(o), 32'h0000_0000, b, v);
  endtask
  // bounded wait so a dead event cannot hang the run
  task automatic wirq(output int n);
    n = 0;
    do
    begin
      tk(1);
      n++;
    end while (irq_o[0] !== 1'b1 && n < 200);
  endtask
  task automatic finish_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #50000;
    err_total++;
    finish_test();
  end
  initial
  begin
    tk(5);
    reset_i = 1'b0;
    chk("sleep", sleep_o, 32'hF);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, BFT_BASE_ADDR + 12'(i) * BFT_INST_STRIDE + 12'(OR), 32'hABCD_0010 + i, 4'hF, v1);
      acc(1'b0, BFT_BASE_ADDR + 12'(i) * BFT_INST_STRIDE + 12'(OR), 32'h0, 4'hF, v1);
      chk("reload", v1, 32'h0000_0010 + i);
      acc(1'b0, BFT_BASE_ADDR + 12'(i) * BFT_INST_STRIDE + 12'(OC), 32'h0, 4'hF, v1);
      chk("count", v1, 32'h0);
    end
    acc(1'b0, 12'hC80, 32'h0, 4'hF, v1);
    chk("unmapped", v1, 32'h0);
    w0(OC, 32'hFFFF_0102);
    r0(OC, 4'hF, v1);
    chk("count", v1, 32'h0000_0102);
    w0(OR, 32'h0000_0102);
    w0(BFT_OFF_CTRL, 32'h0000_0029);
    r0(OC, 4'h1, v1);
    tk(6);
    r0(OC, 4'h2, v2);
    chk("live_hi", v1[15:8], 32'h01);
    chk("snap_hi", v2[15:8], v1[15:8]);
    w0(BFT_OFF_CTRL, 32'h0);
    w0(BFT_OFF_IRQ_EN, 32'h1);
    w0(OR, 32'h2);
    w0(OC, 32'h2);
    w0(BFT_OFF_CTRL, 32'h0001_0029);
    wirq(c);
    tk(1);
    chk("pulse", irq_o[0], 32'h0);
    wirq(c);
    chk("period", c, 32'd5);
    w0(BFT_OFF_CTRL, 32'h0001_00A9);
    r0(OC, 4'hF, v1);
    tk(8);
    r0(OC, 4'hF, v2);
    chk("held", v2, v1);
    chk("halt_sleep", sleep_o[0], 32'h1);
    w0(BFT_OFF_CTRL, 32'h0001_00E9);
    r0(OC, 4'hF, v1);
    chk("reload_cmd", v1, 32'h2);
    w0(BFT_OFF_CTRL, 32'h0);
    w0(OR, 32'hFFFD);
    w0(OC, 32'hFFFD);
    w0(BFT_OFF_CTRL, 32'h0000_002D);
    wirq(c);
    wirq(c);
    chk("up_period", c, 32'd3);
    w0(BFT_OFF_CTRL, 32'h0);
    w0(OC, 32'h2);
    lp_req_i = 4'hF;
    w0(BFT_OFF_CTRL, 32'h0000_0021);
    tk(1);
    chk("grant_run", lp_grant_o[0], 32'h0);
    wirq(c);
    tk(4);
    chk("level", irq_o[0], 32'h1);
    chk("done_sleep", sleep_o[0], 32'h1);
    chk("grant_idle", lp_grant_o[0], 32'h1);
    r0(OC, 4'hF, v1);
    chk("stopped", v1, 32'h0);
    r0(OS, 4'hF, v1);
    chk("status", v1, 32'h1);
    w0(OS, 32'h1);
    tk(2);
    chk("cleared", irq_o[0], 32'h0);
    w0(BFT_OFF_IRQ_EN, 32'h0);
    w0(OC, 32'h1);
    w0(BFT_OFF_CTRL, 32'h0000_0021);
    tk(10);
    chk("gated", irq_o[0], 32'h0);
    r0(OS, 4'hF, v1);
    chk("status", v1, 32'h1);
    w0(BFT_OFF_CTRL, 32'h0000_0010);
    tk(2);
    r0(OR, 4'hF, v1);
    chk("soft_reload", v1, 32'h0);
    r0(OS, 4'hF, v1);
    chk("soft_status", v1, 32'h0);
    finish_test();
  end
endmodule
